// [design/pacc_defs.vh]
// Constants for the proximity and ambient channel configuration block.
// Assumes inclusion by the single design file; holds definitions only.
`ifndef PACC_DEFS_VH
`define PACC_DEFS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PACC_IDX_PROX3_EMITTER_MASK  6'h03
`define PACC_IDX_PROX_ALIGN          6'h05
`define PACC_IDX_AMBIENT_ALIGN       6'h06
`define PACC_IDX_PROX1_INPUT_SELECT  6'h07
`define PACC_IDX_PROX2_INPUT_SELECT  6'h08
`define PACC_IDX_PROX3_INPUT_SELECT  6'h09
`define PACC_IDX_PROX_MODE           6'h20
`define PACC_IDX_STATUS              6'h21
`define PACC_IDX_LAST_RESULT         6'h22

// ----------------------------------------------------------------------
// Reset values and writable-bit masks
// ----------------------------------------------------------------------
`define PACC_RST_EMITTER_MASK  8'h04
`define PACC_RST_ALIGN         8'h00
`define PACC_RST_INPUT_SELECT  8'h03
`define PACC_RST_PROX_MODE     8'h01
`define PACC_MSK_EMITTER_MASK  8'h07
`define PACC_MSK_PROX_ALIGN    8'h70
`define PACC_MSK_AMB_ALIGN     8'h30
`define PACC_MSK_PROX_MODE     8'h01

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PACC_BIT_PROX3_ALIGN  6
`define PACC_BIT_PROX2_ALIGN  5
`define PACC_BIT_PROX1_ALIGN  4
`define PACC_BIT_AMB_BIT5     5
`define PACC_BIT_AMB_BIT4     4

// ----------------------------------------------------------------------
// Measurement channel identifiers
// ----------------------------------------------------------------------
`define PACC_CH_PROX1    3'h0
`define PACC_CH_PROX2    3'h1
`define PACC_CH_PROX3    3'h2
`define PACC_CH_AMB_VIS  3'h3
`define PACC_CH_AMB_IR   3'h4

// ----------------------------------------------------------------------
// Converter input selector codes
// ----------------------------------------------------------------------
`define PACC_SEL_SMALL_IR  8'h00
`define PACC_SEL_VISIBLE   8'h02
`define PACC_SEL_LARGE_IR  8'h03
`define PACC_SEL_NO_DIODE  8'h06
`define PACC_SEL_GROUND    8'h25
`define PACC_SEL_TEMP      8'h65
`define PACC_SEL_SUPPLY    8'h75

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define PACC_RESP_OKAY    2'h0
`define PACC_RESP_SLVERR  2'h2

`endif

// [design/pacc_channel_config.v]
// Configuration and result alignment for three proximity and two ambient channels.
// Assumes an AXI4-Lite master on aclk and a measurement sequencer on the same clock.
//
// Functional notes
// - third channel mask bits select emitters one..three
// - any mask combination drives selected emitters together
// - third emitter mask resets to 0x04
// - bit 6 picks low 16 bits, third result
// - bit 5 picks low 16 bits, second result
// - bit 4 picks low 16 bits, first result
// - ambient bit 5 aligns the visible measurement
// - ambient bit 4 aligns the infrared measurement
// - first selector routes source, resets to 0x03
// - normal mode allows only 0x03 and 0x00
// - raw mode disables emitters, raw conversions
// - raw mode adds 0x02, 0x06, 0x25
// - raw mode adds 0x65 and 0x75
// - second selector mirrors first selector behaviour
// - third selector mirrors first, resets 0x03
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "pacc_defs.vh"

module pacc_channel_config
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        meas_start,
  input  wire [2:0]  meas_channel,
  input  wire        conv_done,
  input  wire [16:0] conv_sample,
  output reg         meas_active,
  output reg  [2:0]  emitter_drive,
  output reg  [7:0]  adc_input_code,
  output reg         raw_conversion,
  output reg         input_code_legal,
  output reg  [15:0] result_data,
  output reg  [2:0]  result_channel,
  output reg         result_valid
);

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  reg  [2:0]  third_prox_emitter_mask;
  reg  [7:0]  prox_alignment_entry;
  reg  [7:0]  ambient_alignment_entry;
  reg  [7:0]  first_prox_input_selector;
  reg  [7:0]  second_prox_input_selector;
  reg  [7:0]  third_prox_input_selector;
  reg         proximity_normal_mode_bit;
  reg  [2:0]  active_channel;
  reg         code_illegal_seen;

  // Byte-wide constants seen through their narrow register widths.
  localparam [7:0] EMITTER_RST_BYTE = `PACC_RST_EMITTER_MASK;
  localparam [7:0] EMITTER_MSK_BYTE = `PACC_MSK_EMITTER_MASK;
  localparam [7:0] MODE_RST_BYTE    = `PACC_RST_PROX_MODE;

  // Write channel holding state.
  reg         aw_held;
  reg  [5:0]  aw_index;
  reg         w_held;
  reg  [7:0]  w_byte;
  reg         w_lane0;

  wire        aw_take   = s_axi_awvalid & s_axi_awready;
  wire        w_take    = s_axi_wvalid & s_axi_wready;
  wire        have_aw   = aw_held | aw_take;
  wire        have_w    = w_held | w_take;
  wire [5:0]  wr_index  = aw_held ? aw_index : s_axi_awaddr[7:2];
  wire [7:0]  wr_byte   = w_held ? w_byte : s_axi_wdata[7:0];
  wire        wr_lane0  = w_held ? w_lane0 : s_axi_wstrb[0];
  wire        wr_fire   = have_aw & have_w & ~s_axi_bvalid;
  wire        wr_en     = wr_fire & wr_lane0;

  // Selector code legality in the current mode.
  function code_ok;
    input [7:0] code;
    input       normal;
    begin
      code_ok = (code == `PACC_SEL_LARGE_IR) || (code == `PACC_SEL_SMALL_IR);
      if (!normal)
      begin
        code_ok = code_ok || (code == `PACC_SEL_VISIBLE)
                  || (code == `PACC_SEL_NO_DIODE)
                  || (code == `PACC_SEL_GROUND);
        code_ok = code_ok || (code == `PACC_SEL_TEMP)
                  || (code == `PACC_SEL_SUPPLY);
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------------
  // Address and data are taken in either order; the response follows both.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PACC_RESP_OKAY;
      aw_held       <= 1'b0;
      aw_index      <= 6'h00;
      w_held        <= 1'b0;
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
    end
    else
    begin
      s_axi_awready <= ~have_aw & ~s_axi_bvalid;
      s_axi_wready  <= ~have_w & ~s_axi_bvalid;
      if (aw_take)
      begin
        aw_index <= s_axi_awaddr[7:2];
      end
      if (w_take)
      begin
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      aw_held <= have_aw & ~wr_fire;
      w_held  <= have_w & ~wr_fire;
      if (wr_fire)
      begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        if ((wr_index == `PACC_IDX_PROX3_EMITTER_MASK) ||
            (wr_index == `PACC_IDX_PROX_ALIGN) ||
            (wr_index == `PACC_IDX_AMBIENT_ALIGN) ||
            (wr_index == `PACC_IDX_PROX1_INPUT_SELECT) ||
            (wr_index == `PACC_IDX_PROX2_INPUT_SELECT) ||
            (wr_index == `PACC_IDX_PROX3_INPUT_SELECT) ||
            (wr_index == `PACC_IDX_PROX_MODE) ||
            (wr_index == `PACC_IDX_STATUS))
          s_axi_bresp <= `PACC_RESP_OKAY;
        else
          s_axi_bresp <= `PACC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  // Reserved bits are dropped on write and read back as zero.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      third_prox_emitter_mask    <= EMITTER_RST_BYTE[2:0];
      prox_alignment_entry       <= `PACC_RST_ALIGN;
      ambient_alignment_entry    <= `PACC_RST_ALIGN;
      first_prox_input_selector  <= `PACC_RST_INPUT_SELECT;
      second_prox_input_selector <= `PACC_RST_INPUT_SELECT;
      third_prox_input_selector  <= `PACC_RST_INPUT_SELECT;
      proximity_normal_mode_bit  <= MODE_RST_BYTE[0];
    end
    else if (wr_en)
    begin
      if (wr_index == `PACC_IDX_PROX3_EMITTER_MASK)
        third_prox_emitter_mask <= wr_byte[2:0] & EMITTER_MSK_BYTE[2:0];
      else if (wr_index == `PACC_IDX_PROX_ALIGN)
        prox_alignment_entry <= wr_byte & `PACC_MSK_PROX_ALIGN;
      else if (wr_index == `PACC_IDX_AMBIENT_ALIGN)
        ambient_alignment_entry <= wr_byte & `PACC_MSK_AMB_ALIGN;
      else if (wr_index == `PACC_IDX_PROX1_INPUT_SELECT)
        first_prox_input_selector <= wr_byte;
      else if (wr_index == `PACC_IDX_PROX2_INPUT_SELECT)
        second_prox_input_selector <= wr_byte;
      else if (wr_index == `PACC_IDX_PROX3_INPUT_SELECT)
        third_prox_input_selector <= wr_byte;
      else if (wr_index == `PACC_IDX_PROX_MODE)
        proximity_normal_mode_bit <= wr_byte[0];
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------
  // Read data is formed from the word index at the address handshake.
  wire [5:0]  rd_index = s_axi_araddr[7:2];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PACC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `PACC_RESP_OKAY;
      if (rd_index == `PACC_IDX_PROX3_EMITTER_MASK)
        s_axi_rdata <= {29'h00000000, third_prox_emitter_mask};
      else if (rd_index == `PACC_IDX_PROX_ALIGN)
        s_axi_rdata <= {24'h000000, prox_alignment_entry};
      else if (rd_index == `PACC_IDX_AMBIENT_ALIGN)
        s_axi_rdata <= {24'h000000, ambient_alignment_entry};
      else if (rd_index == `PACC_IDX_PROX1_INPUT_SELECT)
        s_axi_rdata <= {24'h000000, first_prox_input_selector};
      else if (rd_index == `PACC_IDX_PROX2_INPUT_SELECT)
        s_axi_rdata <= {24'h000000, second_prox_input_selector};
      else if (rd_index == `PACC_IDX_PROX3_INPUT_SELECT)
        s_axi_rdata <= {24'h000000, third_prox_input_selector};
      else if (rd_index == `PACC_IDX_PROX_MODE)
        s_axi_rdata <= {31'h00000000, proximity_normal_mode_bit};
      else if (rd_index == `PACC_IDX_STATUS)
        s_axi_rdata <= {27'h0000000, code_illegal_seen, active_channel, meas_active};
      else if (rd_index == `PACC_IDX_LAST_RESULT)
        s_axi_rdata <= {13'h0000, result_channel, result_data};
      else
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `PACC_RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else
      s_axi_arready <= ~s_axi_rvalid;
  end

  // ----------------------------------------------------------------------
  // Measurement setup
  // ----------------------------------------------------------------------
  // Per-channel selector and emitter choice for a starting measurement.
  reg  [7:0]  next_code;
  reg  [2:0]  next_drive;
  reg         next_prox;

  always @*
  begin
    next_code  = `PACC_SEL_LARGE_IR;
    next_drive = 3'h0;
    next_prox  = 1'b1;
    case (meas_channel)
      `PACC_CH_PROX1: next_code = first_prox_input_selector;
      `PACC_CH_PROX2: next_code = second_prox_input_selector;
      `PACC_CH_PROX3:
      begin
        next_code  = third_prox_input_selector;
        next_drive = third_prox_emitter_mask;
      end
      default: next_prox = 1'b0;
    endcase
    if (!proximity_normal_mode_bit)
      next_drive = 3'h0;
  end

  // Drive outputs for the measurement until its conversion completes.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meas_active       <= 1'b0;
      active_channel    <= `PACC_CH_PROX1;
      emitter_drive     <= 3'h0;
      adc_input_code    <= `PACC_RST_INPUT_SELECT;
      raw_conversion    <= 1'b0;
      input_code_legal  <= 1'b1;
    end
    else if (meas_start && !meas_active)
    begin
      meas_active      <= 1'b1;
      active_channel   <= meas_channel;
      emitter_drive    <= next_drive;
      adc_input_code   <= next_code;
      raw_conversion   <= next_prox & ~proximity_normal_mode_bit;
      input_code_legal <= ~next_prox | code_ok(next_code, proximity_normal_mode_bit);
    end
    else if (conv_done && meas_active)
    begin
      meas_active   <= 1'b0;
      emitter_drive <= 3'h0;
    end
  end

  // Sticky illegal-code flag; a flagged start beats a clear in the same cycle.
  always @(posedge aclk)
  begin
    if (!aresetn)
      code_illegal_seen <= 1'b0;
    else if (meas_start && !meas_active && next_prox &&
             !code_ok(next_code, proximity_normal_mode_bit))
      code_illegal_seen <= 1'b1;
    else if (wr_en && wr_index == `PACC_IDX_STATUS && wr_byte[4])
      code_illegal_seen <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Result alignment
  // ----------------------------------------------------------------------
  // Pick the low or high sixteen of the seventeen converter bits.
  reg         low_sel;

  always @*
  begin
    low_sel = 1'b0;
    case (active_channel)
      `PACC_CH_PROX1:   low_sel = prox_alignment_entry[`PACC_BIT_PROX1_ALIGN];
      `PACC_CH_PROX2:   low_sel = prox_alignment_entry[`PACC_BIT_PROX2_ALIGN];
      `PACC_CH_PROX3:   low_sel = prox_alignment_entry[`PACC_BIT_PROX3_ALIGN];
      `PACC_CH_AMB_VIS: low_sel = ambient_alignment_entry[`PACC_BIT_AMB_BIT5];
      `PACC_CH_AMB_IR:  low_sel = ambient_alignment_entry[`PACC_BIT_AMB_BIT4];
      default:          low_sel = 1'b0;
    endcase
  end

  // Capture the aligned result as a one-cycle valid pulse.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result_data    <= 16'h0000;
      result_channel <= `PACC_CH_PROX1;
      result_valid   <= 1'b0;
    end
    else
    begin
      result_valid <= conv_done & meas_active;
      if (conv_done && meas_active)
      begin
        result_data    <= low_sel ? conv_sample[15:0] : conv_sample[16:1];
        result_channel <= active_channel;
      end
    end
  end

endmodule

// [testbench/pacc_channel_config_sva.sv]
// Port checker of the channel configuration block.
// Assumes a bind onto pacc_channel_config, one clock and a synchronous reset.
`timescale 1ns/10ps

module pacc_channel_config_sva
(
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        meas_start,
  input wire        conv_done,
  input wire        meas_active,
  input wire [2:0]  emitter_drive,
  input wire [7:0]  adc_input_code,
  input wire        raw_conversion,
  input wire        input_code_legal,
  input wire        result_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ------------------------------------------------------------
  // Measurement steps
  // ------------------------------------------------------------
  // A start taken while idle, and a finish seen while active.
  sequence s_take;
    meas_start && !meas_active;
  endsequence
  sequence s_done;
    conv_done && meas_active;
  endsequence

  // Start, finish and emitter behaviour of a measurement.
  meas_take_a:
    assert property (s_take |=> meas_active) else $error("start not taken");
  meas_done_a:
    assert property (s_done |=> result_valid && !meas_active && emitter_drive == 3'h0)
      else $error("finish not handled");
  res_pulse_a:
    assert property (result_valid |=> !result_valid) else $error("result pulse too long");
  drive_raw_a:
    assert property (emitter_drive != 3'h0 |-> meas_active && !raw_conversion)
      else $error("emitter driven outside a normal measurement");
  code_hold_a:
    assert property (meas_active && !conv_done |=> $stable(adc_input_code)
      && $stable(emitter_drive)) else $error("selection changed mid measurement");
  norm_code_a:
    assert property (meas_active && !raw_conversion |-> input_code_legal ==
      (adc_input_code == 8'h00 || adc_input_code == 8'h03)) else $error("normal code flag");
  raw_code_a:
    assert property (meas_active && raw_conversion |-> input_code_legal == (adc_input_code
      inside {8'h00, 8'h02, 8'h03, 8'h06, 8'h25, 8'h65, 8'h75})) else $error("raw code flag");

  // ------------------------------------------------------------
  // Register bus answers
  // ------------------------------------------------------------
  // Responses follow their requests and stand until taken.
  wr_resp_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid) else $error("write response late");
  b_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
  rd_resp_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
  r_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped");
endmodule

// [testbench/pacc_channel_config_tb_top.sv]
// Self-checking bench of the channel configuration block, random and corner cases.
// Assumes the design and its checker are compiled before this file.
`timescale 1ns/10ps

module pacc_channel_config_tb_top;
  reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  reg         s_axi_rready, meas_start, conv_done;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb;
  reg  [2:0]  meas_channel;
  reg  [16:0] conv_sample;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        meas_active, raw_conversion, input_code_legal, result_valid;
  wire [2:0]  emitter_drive, result_channel;
  wire [7:0]  adc_input_code;
  wire [15:0] result_data;
  integer     err_count, total_checks, i, j;
  reg  [31:0] seed, rnd;
  reg  [7:0]  mdl [0:6];
  // Register indices, reset values, writable bits and selector codes.
  localparam logic [5:0] IDX [0:6] = '{6'h03, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h20};
  localparam logic [7:0] RST [0:6] = '{8'h04, 8'h00, 8'h00, 8'h03, 8'h03, 8'h03, 8'h01};
  localparam logic [7:0] WM [0:6] = '{8'h07, 8'h70, 8'h30, 8'hFF, 8'hFF, 8'hFF, 8'h01};
  localparam logic [7:0] CODES [0:6] = '{8'h00, 8'h02, 8'h03, 8'h06, 8'h25, 8'h65, 8'h75};

  pacc_channel_config i_dut
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .meas_start, .meas_channel, .conv_done, .conv_sample,
    .meas_active, .emitter_drive, .adc_input_code, .raw_conversion, .input_code_legal,
    .result_data, .result_channel, .result_valid
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Free-running 25 MHz clock.
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Repeatable random source and the expected aligned result.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] algn(input logic [16:0] s, input logic lo);
    return lo ? s[15:0] : s[16:1];
  endfunction

  // Compares a seen value with the expected one and counts both.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One register write; address and data offered together, each released when taken.
  task automatic wr(input logic [5:0] ix, input logic [7:0] d, input logic [3:0] st,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= {ix, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask

  // One register read compared with the expected byte and response.
  task automatic rd(input logic [5:0] ix, input logic [7:0] ex, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {ix, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, {24'h0, ex});
    chk("rresp", s_axi_rresp, er);
  endtask

  // Writes a model entry with reserved bits zero and reads it back.
  task automatic wmod(input int k, input logic [7:0] d);
    mdl[k] = d & WM[k];
    wr(IDX[k], mdl[k], 4'hF, 2'h0);
    rd(IDX[k], mdl[k], 2'h0);
  endtask

  // Runs one measurement and checks selection, emitters and result.
  task automatic meas(input logic [2:0] ch, input logic [16:0] smp);
    logic [7:0] cd;
    logic       nrm, lo, lg;
    logic [2:0] dr;
    nrm = mdl[6][0];
    cd = (ch < 3'h3) ? mdl[3 + ch] : 8'h03;
    lg = (ch > 3'h2) || (cd == 8'h00) || (cd == 8'h03);
    for (j = 0; j < 7; j = j + 1) lg = lg | (!nrm && cd == CODES[j]);
    dr = (ch == 3'h2 && nrm) ? mdl[0][2:0] : 3'h0;
    lo = (ch < 3'h3) ? mdl[1][4 + ch] : mdl[2][8 - ch];
    @(posedge aclk);
    meas_start <= 1'b1;
    meas_channel <= ch;
    @(posedge aclk);
    meas_start <= 1'b0;
    @(posedge aclk);
    chk("active", meas_active, 32'h1);
    chk("drive", emitter_drive, dr);
    chk("code", adc_input_code, cd);
    chk("legal", input_code_legal, lg);
    chk("raw", raw_conversion, ch < 3'h3 && !nrm);
    conv_done <= 1'b1;
    conv_sample <= smp;
    @(posedge aclk);
    conv_done <= 1'b0;
    @(posedge aclk);
    chk("valid", result_valid, 32'h1);
    chk("data", result_data, algn(smp, lo));
    chk("channel", result_channel, ch);
    chk("drive off", emitter_drive, 32'h0);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  // Reset, corner cases, then random traffic.
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
    {s_axi_rready, meas_start, conv_done, s_axi_awaddr, s_axi_araddr} = 19'h00000;
    {s_axi_wdata, s_axi_wstrb, meas_channel, conv_sample} = 56'h0;
    {seed, err_count, total_checks} = {32'h3338F100, 64'h0};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 7; i = i + 1)
    begin
      mdl[i] = RST[i];
      rd(IDX[i], RST[i], 2'h0);
    end
    rd(6'h3F, 8'h00, 2'h2);
    wr(6'h3F, 8'h5A, 4'hF, 2'h2);
    wr(6'h22, 8'h5A, 4'hF, 2'h2);
    wr(6'h07, 8'h25, 4'h0, 2'h0);
    rd(6'h07, 8'h03, 2'h0);
    for (i = 0; i < 8; i = i + 1)
    begin
      wmod(0, i);
      meas(3'h2, xs());
    end
    for (i = 0; i < 14; i = i + 1)
    begin
      wmod(6, i / 7);
      wmod(3 + i % 3, CODES[i % 7]);
      meas(i % 3, xs());
    end
    // The last start used an illegal code on the second proximity channel; the flag clears on a write.
    rd(6'h21, 8'h12, 2'h0);
    wr(6'h21, 8'h10, 4'hF, 2'h0);
    rd(6'h21, 8'h02, 2'h0);
    wmod(1, 8'h70);
    wmod(2, 8'h30);
    for (i = 0; i < 5; i = i + 1) meas(i, xs());
    for (i = 0; i < 60; i = i + 1)
    begin
      rnd = xs();
      wmod(rnd % 7, rnd[15:8]);
      rnd = xs();
      meas(rnd[31:29] % 3'h5, rnd[16:0]);
    end
    print_verdict;
  end

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    #(40 * 20000);
    err_count = err_count + 1;
    print_verdict;
  end
endmodule

bind pacc_channel_config pacc_channel_config_sva i_sva
(
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .meas_start, .conv_done, .meas_active, .emitter_drive,
  .adc_input_code, .raw_conversion, .input_code_legal, .result_valid
);
